// file: bit_sync.sv
// ------------------------------------------------------------------
// Two-stage level synchroniser, one stage pair per bit
// ------------------------------------------------------------------
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage is read only by the second
  always_ff @(posedge clk_i) begin
    meta_ff <= d_i;
    sync_ff <= meta_ff;
  end

  assign q_o = sync_ff;

endmodule : bit_sync

// file: codec_control_port.sv
module codec_control_port (
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic CTRL_SERIAL_CLOCK_I,
  input wire logic CTRL_SERIAL_IN_I,
  output logic SDA_O,
  output logic SDA_OE_B_O,
  output logic CTRL_SERIAL_OUT_O,
  output logic CTRL_SERIAL_OUT_OE_B_O,
  input wire logic ADDR_SELECT_PIN_I,
  output logic SPI_MODE_O,
  output logic [6:0] REG_ADDR_O,
  output logic [7:0] REG_WDATA_O,
  output logic REG_WR_O,
  output logic REG_RD_O,
  input wire logic [7:0] REG_RDATA_I,
  input wire logic [ctrl_port_pkg::NUM_SRC-1:0] INT_SRC_I,
  input wire logic [ctrl_port_pkg::NUM_SRC-1:0] INT_MASK_I,
  input wire logic [ctrl_port_pkg::NUM_SRC-1:0][1:0] INT_TRIG_I,
  input wire logic INT_PUSH_PULL_I,
  output logic INT_O,
  output logic INT_OE_B_O,
  input wire logic ADC_OVF_POS_I,
  input wire logic ADC_OVF_NEG_I,
  output logic OVERFLOW_FLAG_OUT_O,
  output logic OVERFLOW_FLAG_OUT_OE_B_O
);
  import ctrl_port_pkg::*;

  // ----------------------------------------------------------------
  // Mode and frame detection on the pins
  // ----------------------------------------------------------------
  logic spi_mode_ff;
  logic start_tgl_ff;
  logic addr_lsb_ff;
  logic addr_lsb_l;
  logic link_rst_b;
  logic i2c_mode;

  // Sticky SPI selection on the first select-pin fall after reset
  always_ff @(negedge ADDR_SELECT_PIN_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      spi_mode_ff <= 1'b0;
    end else begin
      spi_mode_ff <= 1'b1;
    end
  end

  // Start marker: data falls while clock is high
  always_ff @(negedge CTRL_SERIAL_IN_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      start_tgl_ff <= 1'b0;
    end else if (CTRL_SERIAL_CLOCK_I) begin
      start_tgl_ff <= ~start_tgl_ff;
    end
  end

  // Select high ends an SPI frame; the link side may see no further edge
  assign i2c_mode = ~spi_mode_ff;
  assign link_rst_b = RST_B_I & ~(spi_mode_ff & ADDR_SELECT_PIN_I);

  // Strap level crosses to the link clock; it is static after reset
  bit_sync #(.WIDTH(1)) u_lsb_sync (
    .clk_i(CTRL_SERIAL_CLOCK_I),
    .d_i(addr_lsb_ff),
    .q_o(addr_lsb_l)
  );

  // ----------------------------------------------------------------
  // Link side: byte engine on the serial clock
  // ----------------------------------------------------------------
  link_state_type state_ff;
  link_state_type st_cur;
  link_state_type nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [3:0] cnt_cur;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic [7:0] out_byte_ff;
  logic [7:0] rx_byte;
  logic [7:0] rd_hold_ff;
  logic ack_pend_ff;
  logic start_seen_ff;
  logic start_new;
  logic byte_end;
  logic ack_slot;
  logic addr_hit;
  logic wr_evt;
  logic ptr_evt;
  logic load_rd;
  logic evt_tgl_ff;
  link_evt_type evt_ff;
  logic sda_oe_b_ff;
  logic sda_o_ff;
  logic ctrl_serial_out_ff;
  logic ctrl_serial_out_oe_b_ff;
  logic [2:0] bit_idx;
  logic tx_on;

  // Bit position and address decode
  assign start_new = i2c_mode & (start_tgl_ff != start_seen_ff);
  assign cnt_cur = start_new ? 4'h0 : bit_cnt_ff;
  assign st_cur = start_new ? LS_ADDR : state_ff;
  assign rx_byte = {shift_ff[6:0], CTRL_SERIAL_IN_I};
  assign byte_end = (cnt_cur == LAST_DATA_BIT);
  assign ack_slot = i2c_mode & (cnt_cur == ACK_BIT);
  assign addr_hit = spi_mode_ff ? (rx_byte[7:1] == SPI_CHIP_ADDR)
                  : ((rx_byte[7:3] == CHIP_ADDR_HI) && (rx_byte[1] == addr_lsb_l));
  assign cnt_nxt = ((byte_end & spi_mode_ff) | ack_slot) ? 4'h0 : cnt_cur + 4'h1;

  // Byte sequencing
  always_comb begin
    nxt_state = st_cur;
    nxt_ptr = ptr_ff;
    wr_evt = 1'b0;
    ptr_evt = 1'b0;
    case (st_cur)
      LS_ADDR: begin
        if (byte_end) begin
          nxt_state = !addr_hit ? LS_IGNORE : (rx_byte[0] ? LS_RDATA : LS_PTR);
        end
      end
      LS_PTR: begin
        if (byte_end) begin
          nxt_ptr = rx_byte;
          ptr_evt = 1'b1;
          nxt_state = LS_WDATA;
        end
      end
      LS_WDATA: begin
        if (byte_end) begin
          wr_evt = 1'b1;
          if (ptr_ff[7]) begin
            nxt_ptr = {1'b1, ptr_ff[6:0] + PTR_STEP};
          end
        end
      end
      LS_RDATA: begin
        if (ack_slot && CTRL_SERIAL_IN_I) begin
          nxt_state = LS_IGNORE; // Host declined further bytes
        end
      end
      default: begin
        nxt_state = st_cur;
      end
    endcase
    load_rd = (nxt_state == LS_RDATA) && (cnt_nxt == 4'h0);
    if (load_rd && ptr_ff[7]) begin
      nxt_ptr = {1'b1, ptr_ff[6:0] + PTR_STEP};
    end
  end

  // Frame state, cleared by reset or by select going high in SPI mode
  always_ff @(posedge CTRL_SERIAL_CLOCK_I or negedge link_rst_b) begin
    if (!link_rst_b) begin
      state_ff <= LS_ADDR;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ack_pend_ff <= 1'b0;
      out_byte_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= cnt_nxt;
      shift_ff <= rx_byte;
      ack_pend_ff <= i2c_mode & byte_end & (st_cur != LS_RDATA) & (nxt_state != LS_IGNORE);
      // Read data word from the reference side is steady long before this load
      out_byte_ff <= load_rd ? rd_hold_ff : out_byte_ff;
    end
  end

  // Pointer and event toggle survive between frames
  always_ff @(posedge CTRL_SERIAL_CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ptr_ff <= PTR_RESET;
      start_seen_ff <= 1'b0;
      evt_tgl_ff <= 1'b0;
      evt_ff <= EVT_RESET;
    end else begin
      ptr_ff <= nxt_ptr;
      start_seen_ff <= start_tgl_ff;
      if (wr_evt | ptr_evt | load_rd) begin
        evt_tgl_ff <= ~evt_tgl_ff;
        evt_ff <= '{wr: wr_evt, rd: load_rd, addr: ptr_ff[6:0], data: rx_byte,
                    nxt_addr: nxt_ptr[6:0]};
      end
    end
  end

  // Output bit selection, MSB first
  assign bit_idx = 3'h7 - bit_cnt_ff[2:0];
  assign tx_on = (state_ff == LS_RDATA) && (bit_cnt_ff < ACK_BIT);

  // Drive changes on the falling clock edge
  always_ff @(negedge CTRL_SERIAL_CLOCK_I or negedge link_rst_b) begin
    if (!link_rst_b) begin
      sda_oe_b_ff <= 1'b1;
      sda_o_ff <= 1'b0;
      ctrl_serial_out_ff <= 1'b0;
      ctrl_serial_out_oe_b_ff <= 1'b1;
    end else begin
      sda_o_ff <= 1'b0;
      sda_oe_b_ff <= ~(i2c_mode & (((bit_cnt_ff == ACK_BIT) & ack_pend_ff)
                     | (tx_on & ~out_byte_ff[bit_idx])));
      ctrl_serial_out_ff <= out_byte_ff[bit_idx];
      ctrl_serial_out_oe_b_ff <= ~(spi_mode_ff & tx_on);
    end
  end

  assign SDA_O = sda_o_ff;
  assign SDA_OE_B_O = sda_oe_b_ff;
  assign CTRL_SERIAL_OUT_O = ctrl_serial_out_ff;
  assign CTRL_SERIAL_OUT_OE_B_O = ctrl_serial_out_oe_b_ff;

  // ----------------------------------------------------------------
  // Reference side: strap, event crossing, register strobes
  // ----------------------------------------------------------------
  logic [3:0] ref_sync;
  logic evt_d_ff;
  logic evt_seen;
  logic spi_mode_o_ff;
  logic [6:0] cur_addr_ff;
  logic [6:0] reg_addr_ff;
  logic [7:0] reg_wdata_ff;
  logic reg_wr_ff;
  logic reg_rd_ff;
  logic status_clr;
  logic [NUM_SRC-1:0] status_ff;

  bit_sync #(.WIDTH(4)) u_ref_sync (
    .clk_i(REF_CLK_I),
    .d_i({RST_B_I, ADDR_SELECT_PIN_I, evt_tgl_ff, spi_mode_ff}),
    .q_o(ref_sync)
  );

  // Pin level is caught for as long as reset is seen low
  always_ff @(posedge REF_CLK_I) begin
    if (!ref_sync[3]) begin
      addr_lsb_ff <= ref_sync[2];
    end
  end

  // The event word is steady once its toggle has been synchronised
  assign evt_seen = ref_sync[1] ^ evt_d_ff;
  assign status_clr = reg_rd_ff && (reg_addr_ff == INT_STATUS_ADDR);

  // Register strobes and read-data holding
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      evt_d_ff <= 1'b0;
      spi_mode_o_ff <= 1'b0;
      cur_addr_ff <= PTR_RESET[6:0];
      reg_addr_ff <= PTR_RESET[6:0];
      reg_wdata_ff <= 8'h00;
      reg_wr_ff <= 1'b0;
      reg_rd_ff <= 1'b0;
      rd_hold_ff <= 8'h00;
    end else begin
      evt_d_ff <= ref_sync[1];
      spi_mode_o_ff <= ref_sync[0];
      reg_wr_ff <= evt_seen & evt_ff.wr;
      reg_rd_ff <= evt_seen & evt_ff.rd;
      reg_wdata_ff <= evt_seen ? evt_ff.data : reg_wdata_ff;
      cur_addr_ff <= evt_seen ? evt_ff.nxt_addr : cur_addr_ff;
      reg_addr_ff <= (evt_seen & (evt_ff.wr | evt_ff.rd)) ? evt_ff.addr : cur_addr_ff;
      rd_hold_ff <= (reg_addr_ff == INT_STATUS_ADDR) ? status_ff : REG_RDATA_I;
    end
  end

  assign SPI_MODE_O = spi_mode_o_ff;
  assign REG_ADDR_O = reg_addr_ff;
  assign REG_WDATA_O = reg_wdata_ff;
  assign REG_WR_O = reg_wr_ff;
  assign REG_RD_O = reg_rd_ff;

  // ----------------------------------------------------------------
  // Interrupt latches, one per source
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] src_d_ff;
  logic [NUM_SRC-1:0] src_evt;
  logic irq;
  logic int_o_ff;
  logic int_oe_b_ff;
  logic overflow_flag_out_oe_b_ff;
  logic overflow_flag_out_o_ff;

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    assign src_evt[i] = (INT_TRIG_I[i] == TRIG_RISE) ? (INT_SRC_I[i] & ~src_d_ff[i])
                      : (INT_TRIG_I[i] == TRIG_FALL) ? (~INT_SRC_I[i] & src_d_ff[i])
                      : INT_SRC_I[i];
    // A new event in the clearing cycle wins over the clear
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
        src_d_ff[i] <= 1'b0;
        status_ff[i] <= STATUS_RESET[i];
      end else begin
        src_d_ff[i] <= INT_SRC_I[i];
        status_ff[i] <= src_evt[i] | (status_ff[i] & ~status_clr);
      end
    end
  end

  assign irq = |(status_ff & INT_MASK_I);

  // Pin drivers for interrupt and overflow
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      int_o_ff <= 1'b0;
      int_oe_b_ff <= 1'b1;
      overflow_flag_out_o_ff <= 1'b0;
      overflow_flag_out_oe_b_ff <= 1'b1;
    end else begin
      int_o_ff <= INT_PUSH_PULL_I & irq;
      int_oe_b_ff <= INT_PUSH_PULL_I ? 1'b0 : ~irq;
      overflow_flag_out_o_ff <= 1'b0;
      overflow_flag_out_oe_b_ff <= ~(ADC_OVF_POS_I | ADC_OVF_NEG_I);
    end
  end

  assign INT_O = int_o_ff;
  assign INT_OE_B_O = int_oe_b_ff;
  assign OVERFLOW_FLAG_OUT_O = overflow_flag_out_o_ff;
  assign OVERFLOW_FLAG_OUT_OE_B_O = overflow_flag_out_oe_b_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  status_rise_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (INT_TRIG_I[0] == TRIG_RISE) && INT_SRC_I[0] && !src_d_ff[0] |=> status_ff[0])
    else $error("rising source did not latch");
  status_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (INT_TRIG_I[0] == TRIG_FALL) && status_ff[0] && !status_clr |=> status_ff[0])
    else $error("latched source lost without a status read");
  status_clr_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    status_clr && !src_evt[0] |=> !status_ff[0])
    else $error("status read did not clear the latch");
  mask_gate_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    INT_PUSH_PULL_I && ((status_ff & INT_MASK_I) == '0) |=> !INT_O)
    else $error("masked source reached the interrupt pin");
  int_drive_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    !INT_PUSH_PULL_I && irq |=> !INT_O && !INT_OE_B_O)
    else $error("open-drain interrupt not pulling low");
  overflow_flag_out_pin_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (ADC_OVF_POS_I || ADC_OVF_NEG_I) |=> !OVERFLOW_FLAG_OUT_OE_B_O)
    else $error("overflow pin not asserted");
  wr_strobe_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    evt_seen && evt_ff.wr |=> REG_WR_O && (REG_ADDR_O == $past(evt_ff.addr)) ##1 !REG_WR_O)
    else $error("write strobe wrong");
  ptr_hold_a: assert property (@(posedge CTRL_SERIAL_CLOCK_I) disable iff (!link_rst_b)
    load_rd && !ptr_ff[7] |=> ptr_ff == $past(ptr_ff))
    else $error("fixed pointer moved on read");
  ptr_step_a: assert property (@(posedge CTRL_SERIAL_CLOCK_I) disable iff (!link_rst_b)
    load_rd && ptr_ff[7] |=> ptr_ff[6:0] == $past(ptr_ff[6:0]) + PTR_STEP)
    else $error("pointer did not advance");
  addr_ack_a: assert property (@(posedge CTRL_SERIAL_CLOCK_I) disable iff (!link_rst_b)
    i2c_mode && (st_cur == LS_ADDR) && byte_end && addr_hit |=> ack_pend_ff && !SDA_OE_B_O)
    else $error("matching address not acknowledged");
  ignore_rel_a: assert property (@(posedge CTRL_SERIAL_CLOCK_I) disable iff (!link_rst_b)
    (state_ff == LS_IGNORE) && ($past(state_ff) == LS_IGNORE) |-> SDA_OE_B_O)
    else $error("data line held while ignoring");

endmodule : codec_control_port

// file: codec_control_port_tb_top.sv
module codec_control_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ctrl_port_pkg::*;

  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic ref_clk, rst_b, push_pull, ovf_pos, ovf_neg, scl, dout, sel, sda_o, sda_oe_b;
  logic so, so_oe_b, spi_mode, wr, rd, int_o, int_oe_b, ovf_o, ovf_oe_b;
  logic [NUM_SRC-1:0] src, mask;
  logic [NUM_SRC-1:0][1:0] trig;
  logic [6:0] reg_addr;
  logic [7:0] wdata;
  logic [7:0] mem [128];
  logic [14:0] exp_wr [$];
  logic [6:0] exp_rd [$];
  int err_count = 0;
  int n_checks = 0;
  int seed = 77;
  wire logic line = dout & (sda_oe_b | sda_o); // Open drain with pull-up
  wire logic [7:0] rdata = mem[reg_addr];

  codec_control_port codec_control_port_inst (.REF_CLK_I(ref_clk), .RST_B_I(rst_b),
    .CTRL_SERIAL_CLOCK_I(scl), .CTRL_SERIAL_IN_I(line), .SDA_O(sda_o), .SDA_OE_B_O(sda_oe_b),
    .CTRL_SERIAL_OUT_O(so), .CTRL_SERIAL_OUT_OE_B_O(so_oe_b), .ADDR_SELECT_PIN_I(sel),
    .SPI_MODE_O(spi_mode), .REG_ADDR_O(reg_addr), .REG_WDATA_O(wdata), .REG_WR_O(wr),
    .REG_RD_O(rd), .REG_RDATA_I(rdata), .INT_SRC_I(src), .INT_MASK_I(mask),
    .INT_TRIG_I(trig), .INT_PUSH_PULL_I(push_pull), .INT_O(int_o), .INT_OE_B_O(int_oe_b),
    .ADC_OVF_POS_I(ovf_pos), .ADC_OVF_NEG_I(ovf_neg), .OVERFLOW_FLAG_OUT_O(ovf_o),
    .OVERFLOW_FLAG_OUT_OE_B_O(ovf_oe_b));

  host_model host_model_inst (.scl_o(scl), .dout_o(dout), .sel_o(sel), .line_i(line),
    .miso_i(so), .miso_oe_b_i(so_oe_b));

  // ----------------------------------------------------------------
  // Clock, comparison and verdict
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Writes land in the model memory after matching the expected queue
  always @(posedge ref_clk) begin
    if (wr === 1'b1) begin
      check("wr_extra", {7'h00, exp_wr.size() == 0}, 8'h00);
      if (exp_wr.size() > 0) begin
        check("wr_addr", {1'b0, reg_addr}, {1'b0, exp_wr[0][14:8]});
        check("wr_data", wdata, exp_wr[0][7:0]);
        void'(exp_wr.pop_front());
      end
      mem[reg_addr] <= wdata;
    end
    // Each read strobe names the register whose byte goes out next
    if (rd === 1'b1) begin
      check("rd_extra", {7'h00, exp_rd.size() == 0}, 8'h00);
      if (exp_rd.size() > 0) begin
        check("rd_addr", {1'b0, reg_addr}, {1'b0, exp_rd.pop_front()});
      end
    end
  end

  // ----------------------------------------------------------------
  // Link sequences
  // ----------------------------------------------------------------
  task automatic do_reset(input logic strap);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    host_model_inst.set_sel(strap);
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : do_reset

  // Two-wire write of pointer and n random bytes
  task automatic i2c_wr(input logic [6:0] chip, input logic [7:0] ptr, input int n,
                        input logic hit);
    logic [7:0] rx, d;
    logic ack;
    host_model_inst.start();
    host_model_inst.xfer({chip, 1'b0}, 1'b0, 1'b1, rx, ack);
    check("addr_ack", {7'h00, ack}, {7'h00, ~hit});
    host_model_inst.xfer(ptr, 1'b0, 1'b1, rx, ack);
    check("ptr_ack", {7'h00, ack}, {7'h00, ~hit});
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      host_model_inst.xfer(d, 1'b0, 1'b1, rx, ack);
      check("data_ack", {7'h00, ack}, {7'h00, ~hit});
      if (hit) exp_wr.push_back({ptr[6:0] + (ptr[7] ? 7'(i) : 7'h00), d});
    end
    host_model_inst.stop();
    repeat (8) @(posedge ref_clk);
  endtask : i2c_wr

  // Two-wire read of n bytes, optionally setting the pointer first
  task automatic i2c_rd(input logic [6:0] chip, input logic [7:0] ptr, input int n,
                        input logic set_ptr);
    logic [7:0] rx;
    logic ack;
    if (set_ptr) i2c_wr(chip, ptr, 0, 1'b1);
    for (int i = 0; i < n; i++) exp_rd.push_back(ptr[6:0] + (ptr[7] ? 7'(i) : 7'h00));
    host_model_inst.start();
    host_model_inst.xfer({chip, 1'b1}, 1'b0, 1'b1, rx, ack);
    check("rd_ack", {7'h00, ack}, 8'h00);
    for (int i = 0; i < n; i++) begin
      host_model_inst.xfer(8'hFF, 1'b0, i == n - 1, rx, ack);
      check("rd_data", rx, mem[ptr[6:0] + (ptr[7] ? 7'(i) : 7'h00)]);
    end
    host_model_inst.stop();
    repeat (8) @(posedge ref_clk);
  endtask : i2c_rd

  // SPI frame: address byte, pointer on writes, then n data bytes
  task automatic spi_frame(input logic [7:0] a, input logic [7:0] ptr, input int n,
                           input logic hit);
    logic [7:0] rx, d;
    logic ack;
    host_model_inst.set_sel(1'b0);
    // A read frame loads one byte beyond the last one clocked out
    if (a[0]) begin
      for (int i = 0; i <= n; i++) exp_rd.push_back(ptr[6:0] + (ptr[7] ? 7'(i) : 7'h00));
    end
    host_model_inst.xfer(a, 1'b1, 1'b1, rx, ack);
    if (!a[0]) host_model_inst.xfer(ptr, 1'b1, 1'b1, rx, ack);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      host_model_inst.xfer(d, 1'b1, 1'b1, rx, ack);
      if (a[0]) check("spi_rd", rx, mem[ptr[6:0] + (ptr[7] ? 7'(i) : 7'h00)]);
      else if (hit) exp_wr.push_back({ptr[6:0] + (ptr[7] ? 7'(i) : 7'h00), d});
    end
    host_model_inst.set_sel(1'b1);
    repeat (8) @(posedge ref_clk);
  endtask : spi_frame

  // Interrupt pin in either drive style
  task automatic chk_int(input logic a);
    check("int_pin", {6'h00, int_o, int_oe_b},
          push_pull ? {6'h00, a, 1'b0} : {6'h00, 1'b0, ~a});
  endtask : chk_int

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    src = '0;
    mask = '0;
    trig = '0;
    push_pull = 1'b1;
    ovf_pos = 1'b0;
    ovf_neg = 1'b0;
    for (int i = 0; i < 128; i++) mem[i] = 8'($random(seed));
    mem[INT_STATUS_ADDR] = 8'h01;
    do_reset(1'b1);
    check("spi_mode", {7'h00, spi_mode}, 8'h00);
    i2c_wr(7'h4E, 8'h85, 2, 1'b0);
    i2c_wr(7'h5F, 8'h85, 2, 1'b0);
    i2c_wr(7'h4F, 8'h85, 3, 1'b1);
    i2c_wr(7'h4D, 8'h0A, 2, 1'b1);
    i2c_rd(7'h4F, 8'h86, 3, 1'b1);
    i2c_rd(7'h4F, 8'h0A, 1, 1'b1);
    i2c_rd(7'h4F, 8'h0A, 1, 1'b0);
    // Each trigger code on source 0, drive style alternating
    @(posedge ref_clk) mask <= 8'h01;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk) trig[0] <= k[1:0];
      push_pull <= k[0];
      repeat (6) @(posedge ref_clk);
      chk_int(1'b0);
      src[0] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk_int(k != 2);
      src[0] <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk_int(1'b1);
      i2c_rd(7'h4F, {1'b0, INT_STATUS_ADDR}, 1, 1'b1);
      chk_int(1'b0);
    end
    // Masked source stays off the pin; overflow ignores masks
    @(posedge ref_clk) mask <= 8'h00;
    trig[1] <= TRIG_RISE;
    src[1] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk_int(1'b0);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk) {ovf_pos, ovf_neg} <= k[1:0];
      repeat (6) @(posedge ref_clk);
      check("ovf_pin", {6'h00, ovf_o, ovf_oe_b}, {6'h00, 1'b0, ~(k[1] | k[0])});
    end
    // Second reset with the strap low, then switch to SPI
    do_reset(1'b0);
    i2c_rd(7'h4E, PTR_RESET, 1, 1'b0);
    i2c_wr(7'h4E, 8'h20, 1, 1'b1);
    i2c_wr(7'h4F, 8'h20, 1, 1'b0);
    check("spi_mode", {7'h00, spi_mode}, 8'h00);
    host_model_inst.set_sel(1'b1);
    host_model_inst.set_sel(1'b0);
    repeat (8) @(posedge ref_clk);
    check("spi_mode", {7'h00, spi_mode}, 8'h01);
    host_model_inst.set_sel(1'b1);
    spi_frame(8'h9E, 8'h90, 2, 1'b1);
    spi_frame(8'h9E, 8'h10, 0, 1'b1);
    spi_frame(8'h9F, 8'h10, 2, 1'b1);
    spi_frame(8'h9E, 8'h90, 0, 1'b1);
    spi_frame(8'h9F, 8'h90, 3, 1'b1);
    spi_frame(8'h9A, 8'h90, 1, 1'b0);
    check("wr_left", 8'(exp_wr.size()), 8'h00);
    check("rd_left", 8'(exp_rd.size()), 8'h00);
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #1_000_000;
    err_count++;
    print_verdict();
  end
endmodule : codec_control_port_tb_top

// file: ctrl_port_pkg.sv
package ctrl_port_pkg;

  // ----------------------------------------------------------------
  // Chip addressing
  // ----------------------------------------------------------------
  localparam logic [4:0] CHIP_ADDR_HI = 5'h13;      // Fixed upper five address bits
  localparam logic [6:0] SPI_CHIP_ADDR = 7'h4F;     // Whole 7-bit address in SPI frames
  localparam logic [6:0] INT_STATUS_ADDR = 7'h18;   // Interrupt status register index
  localparam logic [7:0] PTR_RESET = 8'h00;         // Register pointer after reset

  // ----------------------------------------------------------------
  // Bit framing on the link
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;      // Eighth bit of a byte
  localparam logic [3:0] ACK_BIT = 4'h8;            // Acknowledge slot in two-wire mode
  localparam logic [6:0] PTR_STEP = 7'h01;          // Auto-increment step

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 8;
  localparam logic [1:0] TRIG_LEVEL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LS_ADDR,
    LS_PTR,
    LS_WDATA,
    LS_RDATA,
    LS_IGNORE
  } link_state_type;

  // Event word handed from the link side to the reference side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
    logic [6:0] nxt_addr;
  } link_evt_type;

  localparam link_evt_type EVT_RESET = '{wr: 1'b0, rd: 1'b0, addr: 7'h00, data: 8'h00,
                                         nxt_addr: 7'h00};

endpackage : ctrl_port_pkg

// file: host_model.sv
// ------------------------------------------------------------------
// Host master driving the control link in two-wire or SPI form
// ------------------------------------------------------------------
module host_model (
  output logic scl_o,
  output logic dout_o,
  output logic sel_o,
  input wire logic line_i,
  input wire logic miso_i,
  input wire logic miso_oe_b_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;

  // Clock rests high between frames, data only between two-wire frames
  initial begin
    scl_o = 1'b1;
    dout_o = 1'b1;
    sel_o = 1'b1;
  end

  // Strap level or chip select, then let it settle
  task automatic set_sel(input logic v);
    sel_o = v;
    #HALF;
  endtask : set_sel

  // One bit: data moves with clock low, line sampled before the rise
  task automatic bit_io(input logic b, input logic spi, output logic r);
    scl_o = 1'b0;
    #10 dout_o = b;
    #(HALF - 10);
    r = spi ? (miso_oe_b_i ? 1'bx : miso_i) : line_i;
    scl_o = 1'b1;
    #HALF;
  endtask : bit_io

  // Byte MSB first, plus the acknowledge slot in two-wire form
  task automatic xfer(input logic [7:0] tx, input logic spi, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], spi, r);
      rx[i] = r;
    end
    ack = 1'b1;
    if (!spi) bit_io(ack_in, 1'b0, ack);
  endtask : xfer

  // Start: data falls while clock high
  task automatic start();
    dout_o = 1'b1;
    #HALF dout_o = 1'b0;
    #HALF;
  endtask : start

  // Stop: data rises while clock high, clock then rests high
  task automatic stop();
    scl_o = 1'b0;
    #10 dout_o = 1'b0;
    #(HALF - 10) scl_o = 1'b1;
    #HALF dout_o = 1'b1;
    #HALF;
  endtask : stop
endmodule : host_model
